// file: rtl/vfs_defines.vh
/*
 register offsets, field positions, reset values and timing for the voltage
 fault status bank. definitions only; included by the bank's design files.
*/
`ifndef VFS_DEFINES_VH
`define VFS_DEFINES_VH

// register word offsets on the device register port
`define VFS_ADDR_CELL_LOWER 16'h1826
`define VFS_ADDR_CELL_UPPER 16'h1827
`define VFS_ADDR_AUX_OV 16'h1828
`define VFS_ADDR_AUX_UV 16'h1829

// field widths and positions
`define VFS_CELL_LOWER_W 16
`define VFS_CELL_UPPER_W 2
`define VFS_AUX_W 5
`define VFS_CELL16_BIT 0
`define VFS_CELL17_BIT 1
`define VFS_AUX_A_BIT 4

// reset values
`define VFS_RESET_WORD 16'h0000

// clock and sampling
`define VFS_CLK_PERIOD_NS 20
`define VFS_SYNC_STAGES 2

`endif

// file: rtl/vfs_sync.v
/*
 two flip-flop level synchroniser for a bus of comparator fault levels.
 assumes inputs are asynchronous to core_clk; output is stage two only.
*/
`timescale 1ns/1ps
`include "vfs_defines.vh"

module vfs_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // levels
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   reg [W-1:0] meta_r; // first stage, read only by the second

   // both stages clear to zero on reset
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_r <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // vfs_sync

// file: rtl/vfs_flags.v
/*
 bank of sticky fault flags with a read-to-clear port.
 assumes set levels are already in the core_clk domain.
*/
`timescale 1ns/1ps
`include "vfs_defines.vh"

module vfs_flags #(
   parameter W = 1
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // set and clear
   input wire [W-1:0] set_in,
   input wire [W-1:0] clr_mask,
   // held flags
   output reg [W-1:0] flags_r
);

   wire [W-1:0] flags_nxt; // next flag value

   // a set in the clearing cycle survives, so no event is lost
   assign flags_nxt = (flags_r & ~clr_mask) | set_in;

   // flags come out of reset as no-fault
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_r <= {W{1'b0}};
      end else begin
         flags_r <= flags_nxt;
      end
   end

endmodule // vfs_flags

// file: rtl/vfs_status_bank.v
/*
 voltage fault status registers: lower and upper cell under-voltage (limit 1),
 aux input over-voltage and under-voltage, all read-to-clear.
 assumes comparator fault levels are asynchronous, and the register port is a
 simple one-cycle read strobe with a word address from logic on core_clk.
*/
`timescale 1ns/1ps
`include "vfs_defines.vh"

// Function
// - upper cell word: cell17 bit1, cell16 bit0
// - reading upper cell word returns then clears
// - aux over-voltage: input A bit4, 3..0 below
// - aux under-voltage uses same bit layout
// - reading aux over-voltage word clears its flags
// - reading aux under-voltage word clears its flags
// - unused bits read zero, read-only
// - under-voltage flags reset to zero
// - over-voltage flags reset to zero
// - lower cell word: cells 15..0, read clears
module vfs_status_bank (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // comparator fault levels, asynchronous
   input wire [15:0] cell_uv_lower_in,
   input wire [1:0] cell_uv_upper_in,
   input wire [4:0] aux_ov_in,
   input wire [4:0] aux_uv_in,
   // register read port
   input wire rd_en,
   input wire [15:0] rd_addr,
   output reg [15:0] rd_data_r,
   output reg rd_valid_r
);

   // synchronised comparator levels
   wire [15:0] lower_s;
   wire [1:0] upper_s;
   wire [4:0] ov_s;
   wire [4:0] uv_s;
   // held flags
   wire [15:0] lower_f;
   wire [1:0] upper_f;
   wire [4:0] ov_f;
   wire [4:0] uv_f;
   // per-register read selects
   wire sel_lower;
   wire sel_upper;
   wire sel_ov;
   wire sel_uv;
   reg [15:0] rd_data_nxt; // word to return

   // address decode, used for each register
   function hit;
      input [15:0] addr;
      input [15:0] reg_addr;
      begin
         hit = (addr == reg_addr);
      end
   endfunction

   // one synchroniser for all fault levels, keeps the sample coherent
   vfs_sync #(
      .W(28)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({cell_uv_lower_in, cell_uv_upper_in, aux_ov_in, aux_uv_in}),
      .sync_out({lower_s, upper_s, ov_s, uv_s})
   );

   assign sel_lower = rd_en & hit(rd_addr, `VFS_ADDR_CELL_LOWER);
   assign sel_upper = rd_en & hit(rd_addr, `VFS_ADDR_CELL_UPPER);
   assign sel_ov = rd_en & hit(rd_addr, `VFS_ADDR_AUX_OV);
   assign sel_uv = rd_en & hit(rd_addr, `VFS_ADDR_AUX_UV);

   // lower cell flags, cleared by their own read
   vfs_flags #(
      .W(`VFS_CELL_LOWER_W)
   ) u_lower (
      .core_clk(core_clk),
      .rst(rst),
      .set_in(lower_s),
      .clr_mask({16{sel_lower}} & lower_f),
      .flags_r(lower_f)
   );

   // upper cell flags; clear only what was returned set
   vfs_flags #(
      .W(`VFS_CELL_UPPER_W)
   ) u_upper (
      .core_clk(core_clk),
      .rst(rst),
      .set_in(upper_s),
      .clr_mask({2{sel_upper}} & upper_f),
      .flags_r(upper_f)
   );

   // aux over-voltage flags
   vfs_flags #(
      .W(`VFS_AUX_W)
   ) u_ov (
      .core_clk(core_clk),
      .rst(rst),
      .set_in(ov_s),
      .clr_mask({5{sel_ov}} & ov_f),
      .flags_r(ov_f)
   );

   // aux under-voltage flags
   vfs_flags #(
      .W(`VFS_AUX_W)
   ) u_uv (
      .core_clk(core_clk),
      .rst(rst),
      .set_in(uv_s),
      .clr_mask({5{sel_uv}} & uv_f),
      .flags_r(uv_f)
   );

   // read mux; unmapped addresses return zero
   always @* begin
      rd_data_nxt = `VFS_RESET_WORD;
      if (sel_lower) begin
         rd_data_nxt = lower_f;
      end else if (sel_upper) begin
         rd_data_nxt = {14'h0000, upper_f};
      end else if (sel_ov) begin
         rd_data_nxt = {11'h000, ov_f};
      end else if (sel_uv) begin
         rd_data_nxt = {11'h000, uv_f};
      end
   end

   // registered answer, one cycle after the strobe; old value held otherwise
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_r <= `VFS_RESET_WORD;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_en;
         if (rd_en) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

endmodule // vfs_status_bank

// file: bench/vfs_host_model.sv
/* host side of the read port: one read strobe per bench request.
 assumes requests arrive on core_clk edges. */
`timescale 1ns/1ps
module vfs_host_model (
   // clock
   input wire core_clk,
   // bench request
   input wire req,
   input wire [15:0] req_addr,
   // read port
   output reg rd_en = 1'b0,
   output reg [15:0] rd_addr = 16'h0000
);
   // idle address toggles, so a stale word is never decoded by luck
   always @(posedge core_clk) begin
      rd_en <= req;
      rd_addr <= req ? req_addr : ~rd_addr;
   end
endmodule // vfs_host_model

// file: bench/vfs_monitor.sv
/* read port assertions for the status bank.
 assumes one core_clk domain and rst async high. */
`timescale 1ns/1ps
module vfs_monitor (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // watched ports
   input wire [4:0] aux_ov_in,
   input wire rd_en,
   input wire [15:0] rd_addr,
   input wire [15:0] rd_data_r,
   input wire rd_valid_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // read of the aux over-voltage word
   sequence s_ov; rd_en && rd_addr == 16'h1828; endsequence
   property p_ans; rd_en |=> rd_valid_r; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_quiet; !rd_en |=> !rd_valid_r; endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_hold; !rd_valid_r |-> $stable(rd_data_r); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   // mapped words are 0x1826 to 0x1829; everything else answers zero
   property p_unmap;
      rd_en && (rd_addr < 16'h1826 || rd_addr > 16'h1829) |=> rd_data_r == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not zero");
   property p_up; rd_en && rd_addr == 16'h1827 |=> rd_data_r[15:2] == 14'h0000; endproperty
   a_up: assert property (p_up) else $error("upper spare bits");
   property p_aux; rd_en && rd_addr[15:1] == 15'h0c14 |=> rd_data_r[15:5] == 11'h000; endproperty
   a_aux: assert property (p_aux) else $error("aux spare bits");
   property p_stick; aux_ov_in[0] [*5] ##0 s_ov |=> rd_data_r[0]; endproperty
   a_stick: assert property (p_stick) else $error("fault lost");
   property p_clr; (aux_ov_in == 5'h00) [*4] ##0 s_ov ##1 s_ov |=> rd_data_r[4:0] == 5'h00; endproperty
   a_clr: assert property (p_clr) else $error("not cleared");
endmodule // vfs_monitor
bind vfs_status_bank vfs_monitor vfs_monitor_inst (.core_clk, .rst, .aux_ov_in, .rd_en,
   .rd_addr, .rd_data_r, .rd_valid_r);

// file: bench/tb.sv
/* bench for the fault status bank: host model reads, a scorer checks answers.
 assumes a 50 MHz core_clk. */
`timescale 1ns/1ps
module tb;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg [15:0] lo = 16'h0000;
   reg [1:0] up = 2'h0;
   reg [4:0] ov = 5'h00;
   reg [4:0] uv = 5'h00;
   reg req = 1'b0;
   reg [15:0] req_addr = 16'h0000;
   wire rd_en, rd_valid_r;
   wire [15:0] rd_addr, rd_data_r;
   logic [15:0] exp_q[$];
   logic [15:0] e[4];
   logic [31:0] seed = 32'h00000048;
   logic [31:0] v;
   int mismatches = 0;
   int total_checks = 0;
   int i, j;
   always #10 core_clk = ~core_clk;
   vfs_status_bank vfs_status_bank_inst (.core_clk, .rst, .cell_uv_lower_in(lo),
      .cell_uv_upper_in(up), .aux_ov_in(ov), .aux_uv_in(uv), .rd_en, .rd_addr,
      .rd_data_r, .rd_valid_r);
   vfs_host_model vfs_host_model_inst (.core_clk, .req, .req_addr, .rd_en, .rd_addr);
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task check(input string what, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task finish_test();
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // on the next edge, request and note the answer
   task rd(input logic [15:0] a, input logic [15:0] x);
      @(posedge core_clk);
      req <= 1'b1;
      req_addr <= a;
      exp_q.push_back(x);
   endtask
   task idle(input int n);
      @(posedge core_clk);
      req <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   // scorer: each answer against the oldest note
   always @(posedge core_clk) begin
      if (rd_valid_r === 1'b1) begin
         if (exp_q.size() == 0)
            check("spare answer", 16'h0001, 16'h0000);
         else
            check("rd_data_r", rd_data_r, exp_q.pop_front());
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) rd(16'h1826 + i, 16'h0000);
      for (i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hffffffff : xs();
         e = '{v[15:0], {14'h0000, v[17:16]}, {11'h000, v[22:18]}, {11'h000, v[27:23]}};
         idle(0);
         {uv, ov, up, lo} <= v[27:0];
         idle(5);
         {uv, ov, up, lo} <= 28'h0000000;
         idle(5);
         for (j = 0; j < 4; j++) rd(16'h1826 + j, e[j]);
         for (j = 0; j < 4; j++) rd(16'h1826 + j, 16'h0000);
      end
      idle(0);
      ov <= 5'h1f;
      idle(6);
      rd(16'h1828, 16'h001f);
      rd(16'h1828, 16'h001f);
      idle(0);
      ov <= 5'h00;
      idle(6);
      rd(16'h1828, 16'h001f);
      rd(16'h1828, 16'h0000);
      idle(0);
      uv <= 5'h1f;
      idle(6);
      rst <= 1'b1;
      uv <= 5'h00;
      idle(2);
      rst <= 1'b0;
      rd(16'h1829, 16'h0000);
      idle(0);
      for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge core_clk);
      if (exp_q.size() > 0) check("answer count", 16'h0001, 16'h0000);
      finish_test();
   end
endmodule // tb
